/* core/esu_pkg.sv */
/*
  Shared constants, register map and state types of the enhanced serial port.
  Assumes a 32-bit APB slave with byte addresses in the low eight bits.
*/
`default_nettype none
package esu_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_BUF  = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_PWR  = 8'h0C;
  localparam logic [7:0] ADDR_DIVL = 8'h10;
  localparam logic [7:0] ADDR_DIVH = 8'h14;
  localparam logic [7:0] ADDR_SRC  = 8'h18;
  localparam logic [7:0] ADDR_RSTC = 8'h1C;
  // serial_control_reg fields
  localparam int CTL_MODE_HI = 7;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_REN     = 4;
  localparam int CTL_TB8     = 3;
  localparam int CTL_RB8     = 2;
  localparam int CTL_TI      = 1;
  localparam int CTL_RI      = 0;
  // serial_status_reg fields
  localparam int STA_DB      = 7;
  localparam int STA_BRKRST  = 6;
  localparam int STA_BRK     = 1;
  localparam int STA_FE      = 0;
  // power_control_reg fields
  localparam int PWR_DBL     = 7;
  localparam int PWR_FEV     = 6;
  // source select and reset cause fields
  localparam int SRC_BRG     = 0;
  localparam int RSTC_BRK    = 0;
  // bit timing
  localparam logic [3:0] TICK_MID  = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam int         TICKS_PER_BIT = 16;
  localparam int         BRK_BITS  = 11;
  // frame lengths in bits
  localparam logic [3:0] M0_BITS   = 4'h8;
  localparam logic [3:0] M1_BITS   = 4'hA;
  localparam logic [3:0] M9_BITS   = 4'hB;
  localparam logic [3:0] NINTH_IDX = 4'h9;
  localparam logic [3:0] RX8_BITS  = 4'h9;
  localparam logic [3:0] RX9_BITS  = 4'hA;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0,
    MODE_8BIT  = 2'h1,
    MODE_9FIX  = 2'h2,
    MODE_9VAR  = 2'h3
  } esu_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } esu_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_START = 3'b010,
    RX_DATA  = 3'b100
  } esu_rx_state_t;

  function automatic logic esu_is_nine(input esu_mode_t m);
    return m[1];
  endfunction
endpackage
`default_nettype wire

/* core/esu_baud.sv */
/*
  Sixteen-times bit-rate tick for all serial modes.
  Assumes timerOvf is a one-cycle pulse from the external timer.
*/
`timescale 1ns/1ps
`default_nettype none
module esu_baud
  import esu_pkg::*;
#(
  parameter int DIV_W = 16
)(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // configuration
  input  wire esu_mode_t        mode,
  input  wire logic             useBrg,
  input  wire logic             doubler,
  input  wire logic [DIV_W-1:0] divisor,
  // timer overflow pulse
  input  wire logic             timerOvf,
  // tick out
  output logic                  tick16
);
  logic [DIV_W-1:0] brgCnt_r;
  logic             ovfHalf_r;
  logic             cpuHalf_r;

  wire brgTick   = (brgCnt_r == divisor);
  wire timerTick = timerOvf & (doubler | ovfHalf_r);
  wire varTick   = useBrg ? brgTick : timerTick;
  wire fixTick   = doubler | cpuHalf_r;

  // shift mode: one tick per cpu clock gives cpu/16 per bit
  assign tick16 = (mode == MODE_SHIFT) ? 1'b1 :
                  (mode == MODE_9FIX)  ? fixTick : varTick;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      brgCnt_r  <= '0;
      ovfHalf_r <= 1'b0;
      cpuHalf_r <= 1'b0;
    end
    else
    begin
      brgCnt_r  <= brgTick ? '0 : brgCnt_r + 1'b1;
      ovfHalf_r <= timerOvf ? ~ovfHalf_r : ovfHalf_r;
      cpuHalf_r <= ~cpuHalf_r;
    end
  end

  a_fix_half: assert property (@(posedge clk) disable iff (!nrst)
    (mode == MODE_9FIX && !doubler && tick16) |=> !tick16)
    else $error("fixed rate tick not halved");
  a_timer_half: assert property (@(posedge clk) disable iff (!nrst)
    (mode == MODE_8BIT && !useBrg && !doubler && timerOvf && tick16) |=>
      (!timerOvf || !tick16))
    else $error("timer overflow not halved");
endmodule // esu_baud
`default_nettype wire

/* core/esu_brk.sv */
/*
  Break detector: flags a receive line held low for eleven bit times.
  Assumes tick16 runs at sixteen times the bit rate in framed modes.
*/
`timescale 1ns/1ps
`default_nettype none
module esu_brk
  import esu_pkg::*;
#(
  parameter int BITS = BRK_BITS
)(
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // line and timing
  input  wire logic tick16,
  input  wire logic rxdIn,
  // event
  output logic      breakSeen
);
  localparam logic [7:0] LIMIT = 8'(BITS * TICKS_PER_BIT - 1);
  logic [7:0] lowCnt_r;
  logic       armed_r;

  // one pulse per break, re-armed once the line goes high
  assign breakSeen = armed_r & tick16 & ~rxdIn & (lowCnt_r == LIMIT);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lowCnt_r <= '0;
      armed_r  <= 1'b1;
    end
    else
    begin
      lowCnt_r <= rxdIn ? '0 : (tick16 && lowCnt_r != LIMIT) ? lowCnt_r + 8'h01 : lowCnt_r;
      armed_r  <= rxdIn ? 1'b1 : breakSeen ? 1'b0 : armed_r;
    end
  end

  a_brk_once: assert property (@(posedge clk) disable iff (!nrst)
    breakSeen |=> (!breakSeen) [*8])
    else $error("break flagged twice without line release");
endmodule // esu_brk
`default_nettype wire

/* core/esu_uart.sv */
/*
  Enhanced serial port: shift-register mode, 8-bit and 9-bit framed modes,
  transmit double buffer, framing error, break detect and break reset.
  Assumes an APB master on the register side and a remote serial node on the pins.
*/
// What this block does
// - shift mode: data on rxd pin, clock on txd, 8 bits LSB first, cpu/16
// - 8-bit mode frame: low start, 8 data LSB first, high stop
// - 8-bit mode reception stores the stop bit as received ninth bit
// - 9-bit fixed mode frame: start, 8 data, transmit ninth bit, stop
// - 9-bit modes store received ninth bit, stop bit discarded
// - 9-bit fixed mode runs at cpu/16 or cpu/32 by baud doubler
// - 9-bit variable mode equals fixed mode but uses timer or divisor rate
// - baud generator is a 16-bit divisor from two 8-bit registers
// - timer overflow source halved again when baud doubler is clear
// - framing error in status; control bit 7 shows it when view selected
// - break flagged when receive line low for 11 bit times in framed modes
// - break can request device reset into boot loader mode
// - double buffer takes next byte while shifting; one stop bit between
// - double buffer off: holding buffer still queues the next byte in framed modes; transmit flag set at end of frame
// - double buffer on in framed modes: transmit flag set when holding buffer frees
// - double buffer latches transmit ninth bit with the data byte
// - baud source: cpu constant, timer overflow or divisor generator
// - after break reset fetch starts at boot address
// - reset cause holds break reset flag, cleared by writing 0
`timescale 1ns/1ps
`default_nettype none
module esu_uart
  import esu_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // baud source
  input  wire logic        timerOvf,
  // serial pins
  output logic             txd,
  input  wire logic        rxdIn,
  output logic             rxdOut,
  output logic             rxdOe_n,
  // system
  output logic             devResetReq,
  output logic             bootAddrSel
);
  // software visible state
  esu_mode_t     mode_r;
  logic          ren_r, tb8_r, rb8_r, ti_r, ri_r;
  logic          dbEn_r, brkRstEn_r, brkFlag_r, fe_r;
  logic          dbl_r, fev_r, useBrg_r, rstBrk_r;
  logic [7:0]    divLo_r, divHi_r, rxBuf_r;
  logic [31:0]   prdata_r;
  logic          txd_r, rxdOut_r, rxdOe_n_r, devResetReq_r;
  // transmit engine
  esu_tx_state_t txState_r, txState_nxt;
  logic [10:0]   txShift_r, txShift_nxt;
  logic [3:0]    txCnt_r, txTick_r;
  logic [7:0]    hold_r;
  logic          hold9_r, holdFull_r, m0Rx_r;
  // receive engine
  esu_rx_state_t rxState_r, rxState_nxt;
  logic [9:0]    rxShift_r;
  logic [3:0]    rxTick_r, rxCnt_r;
  logic          tick16, brkSet;

  // apb decode, zero wait states
  wire wrEn   = psel & penable & pwrite;
  wire wrBuf  = wrEn & (paddr == ADDR_BUF);
  wire wrCtl  = wrEn & (paddr == ADDR_CTRL);
  wire wrSta  = wrEn & (paddr == ADDR_STAT);
  wire wrPwr  = wrEn & (paddr == ADDR_PWR);
  wire wrDivL = wrEn & (paddr == ADDR_DIVL);
  wire wrDivH = wrEn & (paddr == ADDR_DIVH);
  wire wrSrc  = wrEn & (paddr == ADDR_SRC);
  wire wrRstc = wrEn & (paddr == ADDR_RSTC);
  wire hit    = (paddr[7:5] == 3'h0) & (paddr[1:0] == 2'h0);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_r;

  wire isShift = (mode_r == MODE_SHIFT);
  wire isNine  = esu_is_nine(mode_r);

  wire [7:0] ctlRd = {fev_r ? fe_r : mode_r[1], mode_r[0], 1'b0, ren_r,
                      tb8_r, rb8_r, ti_r, ri_r};
  wire [7:0] staRd = {dbEn_r, brkRstEn_r, 4'h0, brkFlag_r, fe_r};
  wire [7:0] rdMux = (paddr == ADDR_BUF)  ? rxBuf_r :
                     (paddr == ADDR_CTRL) ? ctlRd :
                     (paddr == ADDR_STAT) ? staRd :
                     (paddr == ADDR_PWR)  ? {dbl_r, fev_r, 6'h00} :
                     (paddr == ADDR_DIVL) ? divLo_r :
                     (paddr == ADDR_DIVH) ? divHi_r :
                     (paddr == ADDR_SRC)  ? {7'h00, useBrg_r} :
                     (paddr == ADDR_RSTC) ? {7'h00, rstBrk_r} : 8'h00;

  esu_baud #(.DIV_W(16)) u_baud (
    .clk      (clk),
    .nrst     (nrst),
    .mode     (mode_r),
    .useBrg   (useBrg_r),
    .doubler  (dbl_r),
    .divisor  ({divHi_r, divLo_r}),
    .timerOvf (timerOvf),
    .tick16   (tick16)
  );

  esu_brk #(.BITS(BRK_BITS)) u_brk (
    .clk       (clk),
    .nrst      (nrst),
    .tick16    (tick16 & ~isShift),
    .rxdIn     (rxdIn),
    .breakSeen (brkSet)
  );
  wire brkRst = brkSet & brkRstEn_r;

  // transmit path
  wire       txIdle    = (txState_r == TX_IDLE);
  wire [3:0] frameBits = isShift ? M0_BITS : isNine ? M9_BITS : M1_BITS;
  wire       bitEnd    = ~txIdle & tick16 & (txTick_r == TICK_LAST);
  wire       lastBit   = bitEnd & (txCnt_r == 4'(frameBits - 4'h1));
  // back-to-back load at end of stop bit keeps a single stop bit
  wire txLoad  = holdFull_r & (txIdle | (lastBit & ~isShift));
  wire m0Start = txIdle & isShift & ren_r & ~ri_r & ~holdFull_r;
  wire [10:0] frameWord = isShift ? {3'h0, hold_r} :
                          isNine  ? {1'b1, hold9_r, hold_r, 1'b0} :
                                    {2'b11, hold_r, 1'b0};
  wire [10:0] m0Word = {3'h0, rxdIn, txShift_r[7:1]};
  wire tiSet = (dbEn_r & ~isShift) ? txLoad :
                                     (lastBit & ~m0Rx_r);
  // single buffer takes the live ninth bit, double buffer the latched one
  wire txBit = (isNine & ~dbEn_r & (txCnt_r == NINTH_IDX)) ? tb8_r
                                                           : txShift_r[0];
  wire lineTx = txIdle ? 1'b1 : isShift ? txTick_r[3] : txBit;

  assign txState_nxt = (txLoad | m0Start) ? TX_SHIFT : lastBit ? TX_IDLE : txState_r;
  assign txShift_nxt = txLoad  ? frameWord :
                       m0Start ? 11'h000 :
                       bitEnd  ? (m0Rx_r ? m0Word : {1'b1, txShift_r[10:1]}) : txShift_r;

  // receive path
  wire       rxMid   = tick16 & (rxTick_r == TICK_MID);
  wire [3:0] rxBits  = isNine ? RX9_BITS : RX8_BITS;
  wire [9:0] rxFull  = {rxdIn, rxShift_r[9:1]};
  wire       rxDone  = (rxState_r == RX_DATA) & rxMid & (rxCnt_r == 4'(rxBits - 4'h1));
  wire       m0Done  = lastBit & m0Rx_r;
  wire [7:0] rxData  = isNine ? rxFull[7:0] : rxFull[8:1];
  wire       rxNinth = isNine ? rxFull[8] : rxFull[9];
  wire       riSet   = rxDone | m0Done;
  wire       feSet   = rxDone & ~rxFull[9];

  always_comb
  begin
    rxState_nxt = rxState_r;
    unique case (rxState_r)
      RX_IDLE:
        if (~isShift & ren_r & ~rxdIn & tick16)
          rxState_nxt = RX_START;
      RX_START:
        if (rxMid)
          rxState_nxt = rxdIn ? RX_IDLE : RX_DATA;
      RX_DATA:
        if (rxDone)
          rxState_nxt = RX_IDLE;
      default:
        rxState_nxt = RX_IDLE;
    endcase
  end

  // flag updates: hardware set wins over a software write
  wire ti_nxt  = tiSet | (wrCtl ? pwdata[CTL_TI] : ti_r);
  wire ri_nxt  = riSet | (wrCtl ? pwdata[CTL_RI] : ri_r);
  wire rb8_nxt = rxDone ? rxNinth : wrCtl ? pwdata[CTL_RB8] : rb8_r;
  wire fe_nxt  = feSet | ((wrCtl & fev_r) ? pwdata[CTL_MODE_HI] :
                          wrSta ? pwdata[STA_FE] : fe_r);
  wire brk_nxt = brkSet | (wrSta ? pwdata[STA_BRK] : brkFlag_r);
  wire rstBrk_nxt = brkRst | ((wrRstc & ~pwdata[RSTC_BRK]) ? 1'b0 : rstBrk_r);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_r <= MODE_SHIFT;
      {ren_r, tb8_r, rb8_r, ti_r, ri_r} <= 5'h00;
      {dbEn_r, brkRstEn_r, brkFlag_r, fe_r} <= 4'h0;
      {dbl_r, fev_r, useBrg_r, rstBrk_r} <= 4'h0;
      {divLo_r, divHi_r, rxBuf_r} <= 24'h000000;
    end
    else
    begin
      if (wrCtl & ~fev_r)
        mode_r <= esu_mode_t'(pwdata[CTL_MODE_HI:CTL_MODE_LO]);
      if (wrCtl & fev_r)
        mode_r <= esu_mode_t'({mode_r[1], pwdata[CTL_MODE_LO]});
      if (wrCtl)
        {ren_r, tb8_r} <= {pwdata[CTL_REN], pwdata[CTL_TB8]};
      {rb8_r, ti_r, ri_r, fe_r, brkFlag_r, rstBrk_r} <=
        {rb8_nxt, ti_nxt, ri_nxt, fe_nxt, brk_nxt, rstBrk_nxt};
      if (wrSta)
        {dbEn_r, brkRstEn_r} <= {pwdata[STA_DB], pwdata[STA_BRKRST]};
      if (wrPwr)
        {dbl_r, fev_r} <= {pwdata[PWR_DBL], pwdata[PWR_FEV]};
      if (wrDivL)
        divLo_r <= pwdata[7:0];
      if (wrDivH)
        divHi_r <= pwdata[7:0];
      if (wrSrc)
        useBrg_r <= pwdata[SRC_BRG];
      if (rxDone)
        rxBuf_r <= rxData;
      else if (m0Done)
        rxBuf_r <= m0Word[7:0];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      txState_r  <= TX_IDLE;
      txShift_r  <= 11'h7FF;
      {txCnt_r, txTick_r} <= 8'h00;
      {hold_r, hold9_r, holdFull_r, m0Rx_r} <= 11'h000;
    end
    else
    begin
      txState_r  <= txState_nxt;
      txShift_r  <= txShift_nxt;
      txCnt_r    <= (txLoad | m0Start) ? 4'h0 : bitEnd ? txCnt_r + 4'h1 : txCnt_r;
      txTick_r   <= (txLoad | m0Start) ? 4'h0 : (~txIdle & tick16) ? txTick_r + 4'h1 : txTick_r;
      holdFull_r <= wrBuf | (holdFull_r & ~txLoad);
      m0Rx_r     <= m0Start | (m0Rx_r & ~lastBit & ~txLoad);
      if (wrBuf)
        {hold_r, hold9_r} <= {pwdata[7:0], tb8_r};
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rxState_r <= RX_IDLE;
      rxShift_r <= 10'h000;
      {rxTick_r, rxCnt_r} <= 8'h00;
    end
    else
    begin
      rxState_r <= rxState_nxt;
      rxTick_r  <= (rxState_r == RX_IDLE) ? 4'h0 : tick16 ? rxTick_r + 4'h1 : rxTick_r;
      rxCnt_r   <= (rxState_r != RX_DATA) ? 4'h0 : rxMid ? rxCnt_r + 4'h1 : rxCnt_r;
      if ((rxState_r == RX_DATA) & rxMid)
        rxShift_r <= rxFull;
    end
  end

  // registered pins and bus read data
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {txd_r, rxdOut_r, rxdOe_n_r} <= 3'b111;
      devResetReq_r <= 1'b0;
      prdata_r      <= 32'h00000000;
    end
    else
    begin
      txd_r         <= lineTx;
      rxdOut_r      <= txShift_r[0];
      rxdOe_n_r     <= ~(~txIdle & isShift & ~m0Rx_r);
      devResetReq_r <= brkRst;
      if (psel & ~penable)
        prdata_r <= {24'h000000, rdMux};
    end
  end

  assign txd         = txd_r;
  assign rxdOut      = rxdOut_r;
  assign rxdOe_n     = rxdOe_n_r;
  assign devResetReq = devResetReq_r;
  assign bootAddrSel = rstBrk_r;

  a_shift_clock: assert property (@(posedge clk) disable iff (!nrst)
    (!txIdle && isShift && !txTick_r[3]) |=> !txd)
    else $error("shift clock not low in first half of bit");
  a_start_low: assert property (@(posedge clk) disable iff (!nrst)
    (txLoad && !isShift) |-> ##2 !txd)
    else $error("start bit not low");
  a_rb8_stop: assert property (@(posedge clk) disable iff (!nrst)
    (rxDone && mode_r == MODE_8BIT) |=> rb8_r == $past(rxdIn))
    else $error("stop bit not stored");
  a_rb8_ninth: assert property (@(posedge clk) disable iff (!nrst)
    (rxDone && isNine) |=> rb8_r == $past(rxShift_r[9]))
    else $error("ninth bit not stored");
  a_brk_reset: assert property (@(posedge clk) disable iff (!nrst)
    (brkSet && brkRstEn_r) |=> (devResetReq && bootAddrSel) ##1 !devResetReq)
    else $error("break reset not one pulse");
  a_ti_early: assert property (@(posedge clk) disable iff (!nrst)
    (txLoad && dbEn_r && !isShift) |=> ti_r)
    else $error("transmit flag not set on buffer free");
  a_ti_single: assert property (@(posedge clk) disable iff (!nrst)
    (!dbEn_r && !ti_r && txLoad && !wrCtl) |=> !ti_r)
    else $error("single buffer flag set at load");
  a_hold_ninth: assert property (@(posedge clk) disable iff (!nrst)
    wrBuf |=> hold9_r == $past(tb8_r))
    else $error("ninth bit not latched with data");
  a_fe_view: assert property (@(posedge clk) disable iff (!nrst)
    (psel && !penable && paddr == ADDR_CTRL && fev_r) |=> prdata[7] == $past(fe_r))
    else $error("control bit 7 not showing framing error");
  a_rst_cause: assert property (@(posedge clk) disable iff (!nrst)
    (wrRstc && !pwdata[RSTC_BRK] && !brkRst) |=> !rstBrk_r)
    else $error("reset cause flag not cleared");
endmodule // esu_uart
`default_nettype wire

/* sim/esu_node.sv */
/*
  Remote serial node on the txd and rxd lines.
  Assumes an idle-high line; the caller gives bit count and bit period in clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module esu_node (
  // clock
  input  wire logic clk,
  // serial line
  input  wire logic txd,
  output logic      rxd
);
  initial rxd = 1'b1;

  // n bits lsb first, then back to idle high
  task automatic send(input logic [11:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++)
    begin
      rxd <= bits[i];
      repeat (per) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask

  // wait for a start bit, sample every bit at its centre
  task automatic recv(input int n, input int per, output logic [11:0] bits, output int idle);
    bits = 12'h000;
    idle = 0;
    while (txd !== 1'b0)
    begin
      @(posedge clk);
      idle++;
    end
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      bits[i] = txd;
      if (i < n - 1)
        repeat (per) @(posedge clk);
    end
  endtask
endmodule // esu_node
`default_nettype wire

/* sim/testbench.sv */
/*
  Self-checking bench for the enhanced serial port.
  Assumes the remote node model on the pins and an APB master in this module.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import esu_pkg::*;
  logic        clk = 1'b0;
  logic        nrst, psel, penable, pwrite, timerOvf;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, err, txd, rxdNode, rxdOut, rxdOe_n;
  logic        devResetReq, bootAddrSel;
  logic [11:0] f1, f2;
  int          idle, miscompares = 0, num_checks = 0, cycles = 0, resetPulses = 0;
  wire logic   rxdLine = rxdOe_n ? rxdNode : rxdOut;

  always #12.5 clk = ~clk;

  esu_uart DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timerOvf(timerOvf), .txd(txd), .rxdIn(rxdLine), .rxdOut(rxdOut), .rxdOe_n(rxdOe_n),
    .devResetReq(devResetReq), .bootAddrSel(bootAddrSel));
  esu_node node (.clk(clk), .txd(txd), .rxd(rxdNode));

  // overflow pulse every second clock; hang guard
  always @(posedge clk)
  begin
    cycles++;
    timerOvf <= ~timerOvf;
    if (devResetReq === 1'b1)
      resetPulses++;
    if (cycles == 40000)
    begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask

  task automatic t_regs();
    rdchk("ctrl reset", ADDR_CTRL, 32'h0);
    rdchk("unmapped read", 8'h20, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("regs done");
  endtask

  task automatic t_tx8();
    int per;
    for (int i = 0; i < 2; i++)
    begin
      per = i ? 64 : 16;
      wr(ADDR_SRC, i ? 32'h0 : 32'h1);
      wr(ADDR_PWR, 32'h0);
      wr(ADDR_DIVL, 32'h0);
      wr(ADDR_DIVH, 32'h0);
      wr(ADDR_CTRL, 32'h50);
      fork
        wr(ADDR_BUF, 32'hA5);
        node.recv(10, per, f1, idle);
      join
      chk("8-bit frame", {22'h0, 1'b1, 8'hA5, 1'b0}, {20'h0, f1});
      repeat (per) @(posedge clk);
      rdchk("single tx flag", ADDR_CTRL, 32'h52);
    end
    $display("tx8 done");
  endtask

  task automatic t_tx9();
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_PWR, i ? 32'h0 : 32'h80);
      wr(ADDR_CTRL, i ? 32'h90 : 32'h98);
      fork
        wr(ADDR_BUF, 32'h3C);
        node.recv(11, i ? 32 : 16, f1, idle);
      join
      chk("9-bit frame", {21'h0, 1'b1, (i == 0), 8'h3C, 1'b0}, {20'h0, f1});
      // let the stop bit finish before the next setup
      repeat (32) @(posedge clk);
      rdchk("9-bit tx flag", ADDR_CTRL, i ? 32'h92 : 32'h9A);
    end
    $display("tx9 done");
  endtask

  task automatic t_rx();
    wr(ADDR_SRC, 32'h1);
    wr(ADDR_DIVL, 32'h1);
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_CTRL, i ? 32'h50 : 32'hD0);
      node.send(i ? {3'b001, 8'h5A, 1'b0} : {2'b01, 1'b0, 8'h96, 1'b0}, i ? 10 : 11, 32);
      repeat (32) @(posedge clk);
      rdchk("rx data", ADDR_BUF, i ? 32'h5A : 32'h96);
      rdchk("rx ninth", ADDR_CTRL, i ? 32'h55 : 32'hD1);
    end
    $display("rx done");
  endtask

  task automatic t_fe();
    wr(ADDR_CTRL, 32'h50);
    node.send({3'b000, 8'h11, 1'b0}, 10, 32);
    repeat (32) @(posedge clk);
    rdchk("frame error", ADDR_STAT, 32'h01);
    wr(ADDR_PWR, 32'h40);
    rdchk("error view", ADDR_CTRL, 32'hD1);
    wr(ADDR_PWR, 32'h0);
    rdchk("mode view", ADDR_CTRL, 32'h51);
    $display("fe done");
  endtask

  task automatic t_brk();
    wr(ADDR_STAT, 32'h40);
    resetPulses = 0;
    node.send(12'h000, 12, 32);
    repeat (32) @(posedge clk);
    chk("reset pulses", 32'h1, resetPulses);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("break flag", 32'h2, q & 32'h2);
    chk("boot select", 32'h1, {31'h0, bootAddrSel});
    rdchk("cause set", ADDR_RSTC, 32'h1);
    wr(ADDR_RSTC, 32'h0);
    rdchk("cause clear", ADDR_RSTC, 32'h0);
    chk("boot clear", 32'h0, {31'h0, bootAddrSel});
    $display("brk done");
  endtask

  task automatic t_dbuf();
    wr(ADDR_DIVL, 32'h0);
    wr(ADDR_STAT, 32'h80);
    wr(ADDR_CTRL, 32'hD8);
    fork
      begin
        wr(ADDR_BUF, 32'h81);
        rdchk("early tx flag", ADDR_CTRL, 32'hDA);
        wr(ADDR_CTRL, 32'hD0);
        wr(ADDR_BUF, 32'h7E);
        wr(ADDR_CTRL, 32'hD8);
      end
      begin
        node.recv(11, 16, f1, idle);
        node.recv(11, 16, f2, idle);
      end
    join
    chk("first frame", {21'h0, 2'b11, 8'h81, 1'b0}, {20'h0, f1});
    chk("second frame", {21'h0, 2'b10, 8'h7E, 1'b0}, {20'h0, f2});
    chk("one stop gap", 32'h1, {31'h0, idle < 12});
    // no mode change before the last stop bit is out
    repeat (16) @(posedge clk);
    $display("dbuf done");
  endtask

  task automatic t_shift();
    logic [7:0] sh;
    int c0;
    wr(ADDR_STAT, 32'h0);
    wr(ADDR_CTRL, 32'h0);
    fork
      wr(ADDR_BUF, 32'hC3);
      for (int i = 0; i < 8; i++)
      begin
        @(posedge txd);
        sh[i] = rxdLine;
        if (i == 0)
          c0 = cycles;
      end
    join
    chk("shift data", 32'hC3, {24'h0, sh});
    chk("shift rate", 32'd112, cycles - c0);
    repeat (16) @(posedge clk);
    // shift receive: data set up mid-bit, sampled at each bit end
    wr(ADDR_CTRL, 32'h10);
    repeat (8) @(posedge clk);
    node.send({4'h0, 8'hB4}, 8, 16);
    rdchk("shift rx data", ADDR_BUF, 32'hB4);
    rdchk("shift rx flag", ADDR_CTRL, 32'h11);
    $display("shift done");
  endtask

  initial
  begin
    nrst     = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    timerOvf = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_tx8();
    t_tx9();
    t_rx();
    t_fe();
    t_brk();
    t_dbuf();
    t_shift();
    conclude();
  end
endmodule // testbench
`default_nettype wire
